// ### verilog/dcf_defs.vh
// shared constants of the clock fan-out control block
`ifndef DCF_DEFS_VH
`define DCF_DEFS_VH
`define DCF_NUM_OUT 10
`define DCF_BYTE0_RST 8'hFF
`define DCF_BYTE1_RST 8'hC0
`define DCF_BYTE1_USED_MASK 8'hC0
`define DCF_DEV_ADDR 8'hD2
`define DCF_LOW_FREQ_NS 50
`define DCF_CLK_NS 4
`define DCF_LOW_FREQ_CYC ((`DCF_LOW_FREQ_NS + `DCF_CLK_NS - 1) / `DCF_CLK_NS)
`define DCF_LOCK_EDGES 4
`define DCF_ST_IDLE 3'h0
`define DCF_ST_ADDR 3'h1
`define DCF_ST_CMD 3'h2
`define DCF_ST_CNT 3'h3
`define DCF_ST_DATA 3'h4
`define DCF_ST_SKIP 3'h5
`endif

// ### verilog/dcf_sync.v
// two-flop synchroniser for a single asynchronous level
`timescale 1ns/1ns
module dcf_sync #(
	parameter RST_VAL = 1'b0
) (
	input wire clk,
	input wire reset_n,
	input wire d,
	output wire q
);
	reg meta_q;
	reg sync_q;
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_q <= RST_VAL;
			sync_q <= RST_VAL;
		end else begin
			meta_q <= d;
			sync_q <= meta_q;
		end
	end
	assign q = sync_q;
endmodule // dcf_sync

// ### verilog/dcf_fanout_ctrl.v
// serial enable register, mode select and glitch-free gating of a 1:10 clock fan-out
`timescale 1ns/1ns
`include "dcf_defs.vh"
// Functional notes
// - one reference pair feeds ten output pairs and one loop pair.
// - each output pair three-states on its own enable bit.
// - low enable bit three-states its pair; high keeps it driving unless supply is up and the reference is too slow.
// - loop output pair ignores the enable bytes; it three-states only when supply is up and the reference is too slow.
// - enable changes take effect only while the reference is low.
// - supply grounded: pll off, outputs follow the reference levels directly.
// - supply up: lock on loop input, outputs aligned to reference edges.
// - serial data is captured on the serial clock rising edge.
// - byte0 bits 7..0 are pairs 0..7, byte1 bits 7,6 pairs 8,9.
module dcf_fanout_ctrl #(
	parameter NUM_OUT = `DCF_NUM_OUT,
	parameter LOW_FREQ_CYC = `DCF_LOW_FREQ_CYC,
	parameter LOCK_EDGES = `DCF_LOCK_EDGES
) (
	input wire clk,
	input wire reset_n,
	input wire ref_in_true,
	input wire ref_in_comp,
	input wire loop_in_true,
	input wire loop_in_comp,
	input wire pll_supply,
	input wire ser_clk_pin,
	input wire ser_data_pin,
	output wire ser_data_out,
	output wire ser_data_oe,
	output wire [NUM_OUT-1:0] fanout_true,
	output wire [NUM_OUT-1:0] fanout_comp,
	output wire [NUM_OUT-1:0] fanout_oe,
	output wire loop_out_true,
	output wire loop_out_comp,
	output wire loop_out_oe,
	output wire pll_on,
	output wire pll_locked,
	output wire ref_too_slow,
	output wire [15:0] enable_reg
);
	wire ref_t_s;
	wire ref_c_s;
	wire loop_t_s;
	wire loop_c_s;
	wire sup_s;
	wire scl_s;
	wire sda_s;
	dcf_sync #(.RST_VAL(1'b0)) u_s_rt (.clk(clk), .reset_n(reset_n), .d(ref_in_true), .q(ref_t_s));
	dcf_sync #(.RST_VAL(1'b1)) u_s_rc (.clk(clk), .reset_n(reset_n), .d(ref_in_comp), .q(ref_c_s));
	dcf_sync #(.RST_VAL(1'b0)) u_s_lt (.clk(clk), .reset_n(reset_n), .d(loop_in_true), .q(loop_t_s));
	dcf_sync #(.RST_VAL(1'b1)) u_s_lc (.clk(clk), .reset_n(reset_n), .d(loop_in_comp), .q(loop_c_s));
	dcf_sync #(.RST_VAL(1'b0)) u_s_sp (.clk(clk), .reset_n(reset_n), .d(pll_supply), .q(sup_s));
	dcf_sync #(.RST_VAL(1'b1)) u_s_cl (.clk(clk), .reset_n(reset_n), .d(ser_clk_pin), .q(scl_s));
	dcf_sync #(.RST_VAL(1'b1)) u_s_da (.clk(clk), .reset_n(reset_n), .d(ser_data_pin), .q(sda_s));

	// edge detection on synchronised serial lines and reference
	reg scl_q;
	reg sda_q;
	reg ref_q;
	reg loop_q;
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			ref_q <= 1'b0;
			loop_q <= 1'b0;
		end else begin
			scl_q <= scl_s;
			sda_q <= sda_s;
			ref_q <= ref_t_s;
			loop_q <= loop_t_s;
		end
	end
	wire scl_rise = scl_s & ~scl_q;
	wire scl_fall = ~scl_s & scl_q;
	wire start_cond = scl_s & scl_q & sda_q & ~sda_s;
	wire stop_cond = scl_s & scl_q & ~sda_q & sda_s;
	wire ref_rise = ref_t_s & ~ref_q;
	wire loop_rise = loop_t_s & ~loop_q & ~loop_c_s;

	// serial write receiver
	reg [2:0] st_q;
	reg [2:0] st_d;
	reg [3:0] bit_q;
	reg [7:0] sh_q;
	reg ack_q;
	reg byte_idx_q;
	reg [7:0] byte0_q;
	reg [7:0] byte1_q;
	wire byte_done = scl_fall & (bit_q == 4'h8);
	wire [7:0] rx_byte = sh_q;
	always @* begin
		st_d = st_q;
		if (byte_done) begin
			case (st_q)
				`DCF_ST_ADDR: st_d = (rx_byte == `DCF_DEV_ADDR) ? `DCF_ST_CMD : `DCF_ST_SKIP;
				`DCF_ST_CMD: st_d = `DCF_ST_CNT;
				`DCF_ST_CNT: st_d = `DCF_ST_DATA;
				`DCF_ST_DATA: st_d = `DCF_ST_DATA;
				default: st_d = st_q;
			endcase
		end
	end
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_q <= `DCF_ST_IDLE;
			bit_q <= 4'h0;
			sh_q <= 8'h00;
			ack_q <= 1'b0;
			byte_idx_q <= 1'b0;
			byte0_q <= `DCF_BYTE0_RST;
			byte1_q <= `DCF_BYTE1_RST;
		end else if (start_cond) begin
			st_q <= `DCF_ST_ADDR;
			bit_q <= 4'h0;
			ack_q <= 1'b0;
			byte_idx_q <= 1'b0;
		end else if (stop_cond) begin
			st_q <= `DCF_ST_IDLE;
			ack_q <= 1'b0;
		end else begin
			st_q <= st_d;
			if (scl_rise && bit_q != 4'h8 && st_q != `DCF_ST_IDLE) begin
				sh_q <= {sh_q[6:0], sda_s};
				bit_q <= bit_q + 4'h1;
			end else if (scl_rise && bit_q == 4'h8) begin
				bit_q <= 4'h9;
			end
			if (byte_done) begin
				ack_q <= (st_d != `DCF_ST_SKIP);
				if (st_q == `DCF_ST_DATA) begin
					byte_idx_q <= 1'b1;
					if (!byte_idx_q)
						byte0_q <= rx_byte;
					else
						byte1_q <= rx_byte & `DCF_BYTE1_USED_MASK;
				end
			end
			if (scl_fall && bit_q == 4'h9) begin
				ack_q <= 1'b0;
				bit_q <= 4'h0;
			end
		end
	end
	assign ser_data_out = 1'b0;
	assign ser_data_oe = ack_q;
	assign enable_reg = {byte0_q, byte1_q};

	// pair i enabled by msb-first bit
	wire [15:0] en_bits = {byte0_q, byte1_q};
	reg [NUM_OUT-1:0] en_eff_q;
	genvar gi;
	generate
		for (gi = 0; gi < NUM_OUT; gi = gi + 1) begin : g_en
			always @(posedge clk or negedge reset_n) begin
				if (!reset_n)
					en_eff_q[gi] <= 1'b1;
				else if (!ref_t_s)
					en_eff_q[gi] <= en_bits[15-gi];
			end
		end
	endgenerate

	// reference frequency watchdog
	reg [15:0] hi_cnt_q;
	reg slow_q;
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			hi_cnt_q <= 16'h0000;
			slow_q <= 1'b1;
		end else if (ref_rise) begin
			hi_cnt_q <= 16'h0000;
			slow_q <= 1'b0;
		end else if (hi_cnt_q >= LOW_FREQ_CYC[15:0]) begin
			slow_q <= 1'b1;
		end else begin
			hi_cnt_q <= hi_cnt_q + 16'h0001;
		end
	end

	// lock tracking on loop input edges
	reg [3:0] lock_cnt_q;
	reg ref_seen_q;
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			lock_cnt_q <= 4'h0;
			ref_seen_q <= 1'b0;
		end else if (!sup_s || slow_q) begin
			lock_cnt_q <= 4'h0;
			ref_seen_q <= 1'b0;
		end else begin
			if (ref_rise)
				ref_seen_q <= 1'b1;
			if (loop_rise && ref_seen_q && lock_cnt_q < LOCK_EDGES[3:0])
				lock_cnt_q <= lock_cnt_q + 4'h1;
		end
	end
	assign pll_on = sup_s & ~slow_q;
	assign pll_locked = pll_on & (lock_cnt_q >= LOCK_EDGES[3:0]);
	assign ref_too_slow = slow_q & sup_s;

	// registered output levels
	reg clk_t_q;
	reg clk_c_q;
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			clk_t_q <= 1'b0;
			clk_c_q <= 1'b1;
		end else begin
			clk_t_q <= ref_t_s;
			clk_c_q <= sup_s ? ~ref_t_s : ref_c_s;
		end
	end
	wire kill = sup_s & slow_q;
	assign fanout_true = {NUM_OUT{clk_t_q}};
	assign fanout_comp = {NUM_OUT{clk_c_q}};
	assign fanout_oe = en_eff_q & {NUM_OUT{~kill}};
	assign loop_out_true = clk_t_q;
	assign loop_out_comp = clk_c_q;
	assign loop_out_oe = ~kill;
endmodule // dcf_fanout_ctrl

// ### tb/dcf_fanout_ctrl_properties.sv
// port checker for the clock fan-out control block
`timescale 1ns/1ns
module dcf_chk (
	input wire clk,
	input wire reset_n,
	input wire ref_in_true,
	input wire pll_supply,
	input wire [9:0] fanout_true,
	input wire [9:0] fanout_oe,
	input wire loop_out_oe,
	input wire pll_on,
	input wire pll_locked,
	input wire ref_too_slow,
	input wire [15:0] enable_reg
);
	wire [9:0] m;
	genvar i;
	for (i = 0; i < 10; i = i + 1) begin : g_m
		assign m[i] = enable_reg[15-i];
	end
	// cycles since the reference last moved with supply up
	reg ref_prev_q;
	reg [7:0] quiet_q;
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ref_prev_q <= 1'b0;
			quiet_q <= 8'h00;
		end else begin
			ref_prev_q <= ref_in_true;
			if (!pll_supply || ref_in_true != ref_prev_q)
				quiet_q <= 8'h00;
			else if (quiet_q != 8'hFF)
				quiet_q <= quiet_q + 8'h01;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	AST_SAME_CLK: assert property (fanout_true == {10{fanout_true[0]}})
		else $error("pairs differ");
	AST_OE_ON: assert property (!(|(fanout_oe & ~$past(fanout_oe) & ~m)))
		else $error("pair on while disabled");
	AST_OE_OFF: assert property (|($past(fanout_oe) & ~fanout_oe & m) |-> ref_too_slow)
		else $error("enabled pair dropped");
	AST_LOOP_OE: assert property ($fell(loop_out_oe) |-> ref_too_slow)
		else $error("loop pair dropped");
	AST_NO_RUNT: assert property ($changed(fanout_oe) && pll_on && $past(pll_on) |->
		!fanout_true[0]) else $error("pair enable moved while clock high");
	AST_BYPASS: assert property (!pll_supply [*5] |-> !pll_on)
		else $error("pll on in bypass");
	AST_LOCK: assert property (pll_locked |-> pll_on)
		else $error("locked while off");
	AST_SLOW: assert property (ref_too_slow [*4] |-> !pll_on && !loop_out_oe)
		else $error("slow ref driving");
	AST_RSVD: assert property (enable_reg[5:0] == 6'h00)
		else $error("reserved bits set");
	AST_SLOW_SEEN: assert property (quiet_q >= 8'h14 |-> ref_too_slow && !loop_out_oe
		&& fanout_oe == 10'h000) else $error("stopped reference not detected");
	cover property ($fell(fanout_oe[0]));
	cover property ($rose(ref_too_slow));
	cover property ($fell(pll_on) && !pll_supply);
endmodule // dcf_chk
bind dcf_fanout_ctrl dcf_chk chk_u (.clk(clk), .reset_n(reset_n), .ref_in_true(ref_in_true),
	.pll_supply(pll_supply),
	.fanout_true(fanout_true), .fanout_oe(fanout_oe), .loop_out_oe(loop_out_oe),
	.pll_on(pll_on), .pll_locked(pll_locked), .ref_too_slow(ref_too_slow),
	.enable_reg(enable_reg));

// ### tb/dcf_master.sv
// serial bus master writing the enable bytes
`timescale 1ns/1ns
module dcf_master (
	input wire clk,
	input wire sda,
	output reg scl,
	output reg sda_low
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task hp;
		repeat (6) @(negedge clk);
	endtask
	task wr(input [7:0] ad, input [7:0] b0, input [7:0] b1, output integer acks);
		reg [39:0] f;
		integer k;
		f = {ad, 8'h00, 8'h02, b0, b1};
		acks = 0;
		sda_low = 1'b1;
		hp;
		for (k = 0; k < 45; k = k + 1) begin
			scl = 1'b0;
			sda_low = (k % 9 == 8) ? 1'b0 : !f[39 - k / 9 * 8 - k % 9];
			hp;
			scl = 1'b1;
			if (k % 9 == 8)
				acks = acks + !sda;
			hp;
		end
		scl = 1'b0;
		sda_low = 1'b1;
		hp;
		scl = 1'b1;
		hp;
		sda_low = 1'b0;
		hp;
	endtask
endmodule // dcf_master

// ### tb/testbench.sv
// testbench for the clock fan-out control block
`timescale 1ns/1ns
module testbench;
	reg clk = 1'b0;
	reg reset_n = 1'b0;
	reg rt = 1'b0;
	reg run = 1'b1;
	reg sup = 1'b1;
	reg cx = 1'b0;
	reg x;
	integer n_checks = 0;
	integer miscompares = 0;
	integer cyc = 0;
	integer a;
	wire scl, sdl, lt, lc, loe, pon, plk, slow, soe;
	wire [9:0] ft, fc, foe;
	wire [15:0] en;
	wire sda = !(sdl || soe);
	always #2 clk = !clk;
	always @(negedge clk) begin
		cyc <= cyc + 1;
		if (run && cyc % 5 == 0)
			rt <= !rt;
		if (cyc == 8000) begin
			miscompares = miscompares + 1;
			end_of_test;
		end
	end
	dcf_master m_u (.clk(clk), .sda(sda), .scl(scl), .sda_low(sdl));
	dcf_fanout_ctrl dut_u (.clk(clk), .reset_n(reset_n), .ref_in_true(rt), .ref_in_comp(!rt ^ cx),
		.loop_in_true(lt), .loop_in_comp(lc), .pll_supply(sup), .ser_clk_pin(scl),
		.ser_data_pin(sda), .ser_data_out(), .ser_data_oe(soe), .fanout_true(ft),
		.fanout_comp(fc), .fanout_oe(foe), .loop_out_true(lt), .loop_out_comp(lc),
		.loop_out_oe(loe), .pll_on(pon), .pll_locked(plk), .ref_too_slow(slow),
		.enable_reg(en));
	task w(input integer n);
		repeat (n) @(negedge clk);
	endtask
	task chk(input [15:0] e, input [15:0] g, input [8*4:1] nm);
		n_checks = n_checks + 1;
		if (g !== e) begin
			miscompares = miscompares + 1;
			$display("BAD %0s exp %h got %h", nm, e, g);
		end
	endtask
	task end_of_test;
		$display("checks %0d bad %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task test_reset(input integer hold);
		reset_n = 1'b0;
		w(hold);
		reset_n = 1'b1;
		w(70);
		chk(16'hFFC0, en, "en");
		chk(10'h3FF, foe, "oe");
		chk(1, plk, "lock");
		chk(1, pon, "pll");
		$display("reset test done");
	endtask
	task test_write;
		m_u.wr(8'hD2, 8'h5A, 8'hBF, a);
		chk(5, a, "ack");
		w(20);
		chk(16'h5A80, en, "en");
		chk(10'h15A, foe, "oe");
		chk(1, loe, "loop");
		chk(10'h3FF, ft ^ fc, "fc");
		chk(ft[0], lt, "lt");
		chk(fc[0], lc, "lc");
		$display("write test done");
	endtask
	task test_bad_addr;
		m_u.wr(8'hD0, 8'h00, 8'h00, a);
		chk(0, a, "ack");
		w(20);
		chk(16'h5A80, en, "en");
		$display("address test done");
	endtask
	task test_bypass;
		sup = 1'b0;
		w(20);
		chk(0, pon, "pll");
		x = ft[1];
		w(5);
		chk(!x, ft[1], "ft");
		chk(!ft[1], fc[1], "fc");
		chk(ft[0], lt, "lt");
		cx = 1'b1;
		w(5);
		chk(ft[1], fc[1], "fc");
		cx = 1'b0;
		sup = 1'b1;
		$display("bypass test done");
	endtask
	task test_slow;
		run = 1'b0;
		w(30);
		chk(1, slow, "slow");
		chk(0, {loe, foe}, "oe");
		chk(0, pon, "pll");
		run = 1'b1;
		w(40);
		chk(1, loe, "loop");
		chk(10'h15A, foe, "oe");
		$display("slow test done");
	endtask
	initial begin
		test_reset(12);
		test_write;
		test_bad_addr;
		test_bypass;
		test_slow;
		test_reset(2);
		end_of_test;
	end
endmodule // testbench
